/* File: rtl/ccr_core_regs.sv */
//Contract
//- 8-bit accumulator holds operands and results of operations.
//- two 8-bit index registers; prefix selects the second one.
//- interrupt context save and restore never touch the second index.
//- 16-bit program counter made of low and high bytes.
//- 8-bit condition codes, bitwise test/change, whole push and pop.
//- half carry set from bit 3 carry on add and add-with-carry only.
//- negative flag copies result bit 7.
//- zero flag set when the result is zero.
//- carry from arithmetic, bit-test, shifts, set and clear carry.
//- branch on each flag set or clear.
//- priority bits encode levels 0 to 3, level 3 disables.
//- interrupt entry loads priority from the source priority register.
//- enable, disable, return, halt, wait, pop change priority.
//- stack pointer at next free byte; post-decrement, pre-increment.
//- 256-byte stack, upper pointer byte fixed by hardware.
//- reset and stack reinit instruction set pointer low byte to ff.
//- load instruction writes pointer low byte directly.
//- pointer wraps silently at both stack limits.
//- interrupt pushes low pc byte first; return pops in reverse.
//- call uses two stack bytes, interrupt uses five.
`timescale 1ns/1ns
`include "ccr_consts.svh"
module ccr_core_regs
  import ccr_pkg::*;
#(
  parameter logic [7:0] SP_HI = `CCR_SP_HI
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire ccr_op_e op_i,
  input wire ccr_reg_e reg_sel_i,
  input wire logic alt_index_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] alu_result_i,
  input wire logic alu_carry_i,
  input wire ccr_flag_e flag_sel_i,
  input wire logic branch_on_set_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [15:0] pc_i,
  input wire logic [1:0] isp_i,
  input wire logic [7:0] stk_rdata_i,
  output logic busy_o,
  output logic [7:0] acc_o,
  output logic [7:0] idx_x_o,
  output logic [7:0] idx_y_o,
  output logic [15:0] pc_o,
  output logic [7:0] cc_o,
  output logic [15:0] sp_o,
  output logic branch_taken_o,
  output logic [15:0] stk_addr_o,
  output logic [7:0] stk_wdata_o,
  output logic stk_we_o,
  output logic stk_re_o
);

  ////////////////////////////////////////////////////////////////////////
  logic op_go;
  logic [7:0] acc;
  logic [7:0] idx_x;
  logic [7:0] idx_y;
  logic [7:0] cc_q;
  logic [7:0] cc_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [7:0] sp_q;
  logic [7:0] sp_d;
  logic taken_q;
  logic taken_d;
  logic a_ld;
  logic x_ld;
  logic y_ld;
  logic [7:0] a_nx;
  logic [7:0] x_nx;
  logic [7:0] y_nx;
  logic [7:0] res_val;
  logic [7:0] sp_inc;
  logic cin;
  logic [4:0] add_nib;
  logic [8:0] add_sum;
  logic half_add;
  logic flag_val;
  logic br_hit;
  logic [2:0] one_slot;

  ccr_state_e state_q;
  ccr_state_e state_d;
  ccr_kind_e kind_q;
  ccr_kind_e kind_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic ph_q;
  logic ph_d;
  logic [2:0] slot_q;
  logic [2:0] slot_d;
  logic [15:0] tgt_q;
  logic [15:0] tgt_d;
  logic [1:0] isp_q;
  logic [1:0] isp_d;
  logic [2:0] seq_len;
  logic last;
  logic push_we;
  logic pop_rd;
  logic pop_cap;
  logic done_irq;
  logic done_call;
  logic [2:0] push_slot;
  logic [2:0] pop_slot;
  logic [7:0] push_byte;

  assign busy_o = (state_q != ST_IDLE);
  // new ops are only taken between stack sequences
  assign op_go = op_valid_i && !busy_o;
  assign sp_inc = sp_q + `CCR_SP_STEP;
  assign res_val = (op_i == OP_LOAD) ? operand_i : alu_result_i;
  assign cin = (op_i == OP_ADC) && cc_q[`CCR_BIT_C];
  assign add_nib = {1'b0, acc[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, cin};
  assign add_sum = {1'b0, acc} + {1'b0, operand_i} + {8'h00, cin};
  assign half_add = add_nib[4];

  always_comb
  begin
    if (reg_sel_i == REG_A)
    begin
      one_slot = `CCR_SLOT_A;
    end
    else if (reg_sel_i == REG_CC)
    begin
      one_slot = `CCR_SLOT_CC;
    end
    else
    begin
      one_slot = alt_index_i ? `CCR_SLOT_Y : `CCR_SLOT_X;
    end
  end

  always_comb
  begin
    unique case (flag_sel_i)
      FLG_H: flag_val = cc_q[`CCR_BIT_H];
      FLG_N: flag_val = cc_q[`CCR_BIT_N];
      FLG_Z: flag_val = cc_q[`CCR_BIT_Z];
      FLG_C: flag_val = cc_q[`CCR_BIT_C];
    endcase
    br_hit = (flag_val == branch_on_set_i);
  end

  ////////////////////////////////////////////////////////////////////////
  // stack sequencer
  always_comb
  begin
    if (kind_q == K_IRQ || kind_q == K_INTERRUPT_RETURN_INSTR)
    begin
      seq_len = `CCR_IRQ_BYTES;
    end
    else if (kind_q == K_CALL || kind_q == K_RET)
    begin
      seq_len = `CCR_CALL_BYTES;
    end
    else
    begin
      seq_len = `CCR_ONE_BYTE;
    end
    last = (cnt_q == 3'(seq_len - `CCR_ONE_BYTE));
    // irq pushes slots in count order: pcl, pch, x, a, cc; call pushes only pcl, pch
    push_slot = (kind_q == K_ONE) ? slot_q : cnt_q;
    if (kind_q == K_INTERRUPT_RETURN_INSTR)
    begin
      pop_slot = 3'(`CCR_IRQ_BYTES - `CCR_ONE_BYTE - cnt_q);
    end
    else if (kind_q == K_RET)
    begin
      pop_slot = 3'(`CCR_CALL_BYTES - `CCR_ONE_BYTE - cnt_q);
    end
    else
    begin
      pop_slot = slot_q;
    end
  end

  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    slot_d = slot_q;
    tgt_d = tgt_q;
    isp_d = isp_q;
    push_we = 1'b0;
    pop_rd = 1'b0;
    pop_cap = 1'b0;
    done_irq = 1'b0;
    done_call = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (op_go)
        begin
          cnt_d = 3'h0;
          ph_d = 1'b0;
          tgt_d = pc_i;
          isp_d = isp_i;
          slot_d = one_slot;
          unique case (op_i)
            OP_PUSH:
            begin
              state_d = ST_PUSH;
              kind_d = K_ONE;
            end
            OP_CALL:
            begin
              state_d = ST_PUSH;
              kind_d = K_CALL;
            end
            OP_IRQ:
            begin
              state_d = ST_PUSH;
              kind_d = K_IRQ;
            end
            OP_POP:
            begin
              state_d = ST_POP;
              kind_d = K_ONE;
            end
            OP_RET:
            begin
              state_d = ST_POP;
              kind_d = K_RET;
            end
            OP_INTERRUPT_RETURN_INSTR:
            begin
              state_d = ST_POP;
              kind_d = K_INTERRUPT_RETURN_INSTR;
            end
            default:
            begin
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_PUSH:
      begin
        push_we = 1'b1;
        cnt_d = 3'(cnt_q + `CCR_ONE_BYTE);
        if (last)
        begin
          state_d = ST_IDLE;
          done_irq = (kind_q == K_IRQ);
          done_call = (kind_q == K_CALL);
        end
      end
      ST_POP:
      begin
        // two cycles a byte: address, then capture of read data
        if (!ph_q)
        begin
          pop_rd = 1'b1;
          ph_d = 1'b1;
        end
        else
        begin
          pop_cap = 1'b1;
          ph_d = 1'b0;
          cnt_d = 3'(cnt_q + `CCR_ONE_BYTE);
          if (last)
          begin
            state_d = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      kind_q <= K_ONE;
      cnt_q <= 3'h0;
      ph_q <= 1'b0;
      slot_q <= 3'h0;
      tgt_q <= 16'h0000;
      isp_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      slot_q <= slot_d;
      tgt_q <= tgt_d;
      isp_q <= isp_d;
    end
  end

  // x, never y, goes into the interrupt frame
  always_comb
  begin
    unique case (push_slot)
      `CCR_SLOT_PCL: push_byte = pc_q[7:0];
      `CCR_SLOT_PCH: push_byte = pc_q[15:8];
      `CCR_SLOT_X: push_byte = idx_x;
      `CCR_SLOT_A: push_byte = acc;
      `CCR_SLOT_CC: push_byte = cc_q;
      `CCR_SLOT_Y: push_byte = idx_y;
      default: push_byte = 8'h00;
    endcase
  end

  assign stk_we_o = push_we;
  assign stk_re_o = pop_rd;
  assign stk_wdata_o = push_byte;
  assign stk_addr_o = {SP_HI, pop_rd ? sp_inc : sp_q};

  ////////////////////////////////////////////////////////////////////////
  // architectural registers
  always_comb
  begin
    cc_d = cc_q;
    pc_d = pc_q;
    sp_d = sp_q;
    taken_d = taken_q;
    a_ld = 1'b0;
    x_ld = 1'b0;
    y_ld = 1'b0;
    a_nx = res_val;
    x_nx = res_val;
    y_nx = res_val;
    if (op_go)
    begin
      unique case (op_i)
        OP_ADD, OP_ADC:
        begin
          a_ld = 1'b1;
          a_nx = add_sum[7:0];
          cc_d[`CCR_BIT_H] = half_add;
          cc_d[`CCR_BIT_N] = add_sum[7];
          cc_d[`CCR_BIT_Z] = (add_sum[7:0] == 8'h00);
          cc_d[`CCR_BIT_C] = add_sum[8];
        end
        OP_ALU, OP_LOAD, OP_SHIFT:
        begin
          if (reg_sel_i == REG_A)
          begin
            a_ld = 1'b1;
          end
          else if (alt_index_i)
          begin
            y_ld = 1'b1;
          end
          else
          begin
            x_ld = 1'b1;
          end
          cc_d[`CCR_BIT_N] = res_val[7];
          cc_d[`CCR_BIT_Z] = (res_val == 8'h00);
          if (op_i == OP_SHIFT)
          begin
            cc_d[`CCR_BIT_C] = alu_carry_i;
          end
        end
        OP_BTJ: cc_d[`CCR_BIT_C] = alu_carry_i;
        OP_SCF: cc_d[`CCR_BIT_C] = 1'b1;
        OP_RCF: cc_d[`CCR_BIT_C] = 1'b0;
        OP_RIM, OP_HALT, OP_WFI:
        begin
          {cc_d[`CCR_BIT_I1], cc_d[`CCR_BIT_I0]} = `CCR_PRIO_LVL0;
        end
        OP_SIM:
        begin
          {cc_d[`CCR_BIT_I1], cc_d[`CCR_BIT_I0]} = `CCR_PRIO_LVL3;
        end
        OP_CCBIT: cc_d[bit_sel_i] = operand_i[0];
        OP_RSP: sp_d = `CCR_SP_LO_RST;
        OP_LDSP: sp_d = operand_i;
        OP_JUMP: pc_d = pc_i;
        OP_BRANCH:
        begin
          taken_d = br_hit;
          if (br_hit)
          begin
            pc_d = pc_i;
          end
        end
        default:
        begin
          taken_d = taken_q;
        end
      endcase
    end
    // 8-bit arithmetic wraps silently at both ends of the stack
    if (push_we)
    begin
      sp_d = sp_q - `CCR_SP_STEP;
    end
    if (pop_rd)
    begin
      sp_d = sp_inc;
    end
    if (pop_cap)
    begin
      unique case (pop_slot)
        `CCR_SLOT_PCL: pc_d[7:0] = stk_rdata_i;
        `CCR_SLOT_PCH: pc_d[15:8] = stk_rdata_i;
        `CCR_SLOT_X:
        begin
          x_ld = 1'b1;
          x_nx = stk_rdata_i;
        end
        `CCR_SLOT_A:
        begin
          a_ld = 1'b1;
          a_nx = stk_rdata_i;
        end
        `CCR_SLOT_CC: cc_d = stk_rdata_i;
        `CCR_SLOT_Y:
        begin
          y_ld = 1'b1;
          y_nx = stk_rdata_i;
        end
        default:
        begin
          x_ld = 1'b0;
        end
      endcase
    end
    if (done_irq || done_call)
    begin
      pc_d = tgt_q;
    end
    if (done_irq)
    begin
      cc_d[`CCR_BIT_I1] = isp_q[1];
      cc_d[`CCR_BIT_I0] = isp_q[0];
    end
    cc_d = cc_d | `CCR_FIXED_ONES;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cc_q <= `CCR_CC_RST;
      pc_q <= 16'h0000;
      sp_q <= `CCR_SP_LO_RST;
      taken_q <= 1'b0;
    end
    else
    begin
      cc_q <= cc_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      taken_q <= taken_d;
    end
  end

  ccr_reg8 #(.WIDTH(8)) u_acc (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ld_i(a_ld), .d_i(a_nx), .q_o(acc)
  );
  ccr_reg8 #(.WIDTH(8)) u_idx_x (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ld_i(x_ld), .d_i(x_nx), .q_o(idx_x)
  );
  ccr_reg8 #(.WIDTH(8)) u_idx_y (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ld_i(y_ld), .d_i(y_nx), .q_o(idx_y)
  );

  assign acc_o = acc;
  assign idx_x_o = idx_x;
  assign idx_y_o = idx_y;
  assign pc_o = pc_q;
  assign cc_o = cc_q;
  assign sp_o = {SP_HI, sp_q};
  assign branch_taken_o = taken_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic wr_msb;
  logic [1:0] prio_now;
  logic irq_ctx;
  assign wr_msb = operand_i[7];
  assign prio_now = {cc_o[`CCR_BIT_I1], cc_o[`CCR_BIT_I0]};
  assign irq_ctx = busy_o && (kind_q == K_IRQ || kind_q == K_INTERRUPT_RETURN_INSTR);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_CC_FIXED: assert property (cc_o[7:6] == 2'b11)
    else $error("fixed condition-code bits not one");
  AST_SP_HIGH: assert property (sp_o[15:8] == SP_HI)
    else $error("stack pointer high byte moved");
  AST_RSP: assert property (op_go && op_i == OP_RSP |=> sp_o[7:0] == 8'hff)
    else $error("stack reinit did not set low byte");
  AST_HALF: assert property (op_go && (op_i == OP_ADD || op_i == OP_ADC)
    |=> cc_o[4] == $past(half_add))
    else $error("half carry wrong after add");
  AST_LOAD_NZ: assert property (op_go && op_i == OP_LOAD
    |=> cc_o[2] == $past(wr_msb) && cc_o[1] == ($past(operand_i) == 8'h00))
    else $error("negative or zero flag wrong after load");
  AST_PUSH_DEC: assert property (stk_we_o
    |=> sp_o[7:0] == 8'($past(sp_q) - 8'h01))
    else $error("stack pointer not decremented after push");
  AST_IRQ_LEN: assert property (op_go && op_i == OP_IRQ
    |=> stk_we_o [*5] ##1 !busy_o)
    else $error("interrupt frame is not five bytes");
  AST_CALL_LEN: assert property (op_go && op_i == OP_CALL
    |=> stk_we_o [*2] ##1 !stk_we_o)
    else $error("call frame is not two bytes");
  AST_IRQ_PRIO: assert property (op_go && op_i == OP_IRQ
    |-> ##6 prio_now == $past(isp_i, 6))
    else $error("priority not loaded on interrupt entry");
  AST_Y_KEEP: assert property (irq_ctx |=> $stable(idx_y_o))
    else $error("second index changed by interrupt context");
  AST_SIM: assert property (op_go && op_i == OP_SIM |=> prio_now == 2'b11)
    else $error("disable did not reach level 3");

  COV_IRQ: cover property (op_go && op_i == OP_IRQ ##6 !busy_o);
  COV_INTERRUPT_RETURN_INSTR: cover property (op_go && op_i == OP_INTERRUPT_RETURN_INSTR);
  COV_BRANCH: cover property (op_go && op_i == OP_BRANCH ##1 branch_taken_o);
  COV_WRAP: cover property (stk_we_o && sp_q == 8'h00);
endmodule : ccr_core_regs

/* File: rtl/ccr_consts.svh */
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// condition-code bit positions
`define CCR_BIT_C 0
`define CCR_BIT_Z 1
`define CCR_BIT_N 2
`define CCR_BIT_I0 3
`define CCR_BIT_H 4
`define CCR_BIT_I1 5
`define CCR_FIXED_ONES 8'hc0
`define CCR_CC_RST 8'he8

// stack pointer
`define CCR_SP_LO_RST 8'hff
`define CCR_SP_HI 8'h01
`define CCR_SP_STEP 8'h01

// software priority codes {high, low}
`define CCR_PRIO_LVL0 2'b10
`define CCR_PRIO_LVL3 2'b11

// stack sequence lengths in bytes
`define CCR_ONE_BYTE 3'd1
`define CCR_CALL_BYTES 3'd2
`define CCR_IRQ_BYTES 3'd5

// stack byte slots
`define CCR_SLOT_PCL 3'd0
`define CCR_SLOT_PCH 3'd1
`define CCR_SLOT_X 3'd2
`define CCR_SLOT_A 3'd3
`define CCR_SLOT_CC 3'd4
`define CCR_SLOT_Y 3'd5

`endif

/* File: rtl/ccr_pkg.sv */
package ccr_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_ALU, OP_LOAD, OP_SHIFT, OP_BTJ, OP_SCF,
    OP_RCF, OP_RIM, OP_SIM, OP_HALT, OP_WFI, OP_PUSH, OP_POP, OP_CALL,
    OP_RET, OP_IRQ, OP_INTERRUPT_RETURN_INSTR, OP_RSP, OP_LDSP, OP_JUMP, OP_BRANCH, OP_CCBIT
  } ccr_op_e;

  typedef enum logic [1:0] {REG_A, REG_X, REG_CC} ccr_reg_e;

  typedef enum logic [1:0] {FLG_H, FLG_N, FLG_Z, FLG_C} ccr_flag_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_POP = 2'b11
  } ccr_state_e;

  typedef enum logic [2:0] {K_ONE, K_CALL, K_IRQ, K_RET, K_INTERRUPT_RETURN_INSTR} ccr_kind_e;

endpackage : ccr_pkg

/* File: rtl/ccr_reg8.sv */
`timescale 1ns/1ns
module ccr_reg8 #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ld_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] val_q;
  logic [WIDTH-1:0] val_d;

  always_comb
  begin
    val_d = ld_i ? d_i : val_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      val_q <= {WIDTH{1'b0}};
    end
    else
    begin
      val_q <= val_d;
    end
  end

  assign q_o = val_q;
endmodule : ccr_reg8

/* File: test/cpu_core_registers_bench.sv */
`timescale 1ns/1ns
module cpu_core_registers_bench
  import ccr_pkg::*;
;
  localparam logic [7:0] SPH = 8'h01;
  logic sys_clk_i;
  logic rst_i;
  logic op_valid_i;
  ccr_op_e op_i;
  ccr_reg_e reg_sel_i;
  logic alt_index_i;
  logic [7:0] operand_i;
  logic [7:0] alu_result_i;
  logic alu_carry_i;
  ccr_flag_e flag_sel_i;
  logic branch_on_set_i;
  logic [2:0] bit_sel_i;
  logic [15:0] pc_i;
  logic [1:0] isp_i;
  logic [7:0] stk_rdata_i = 8'h00;
  logic busy_o;
  logic [7:0] acc_o;
  logic [7:0] idx_x_o;
  logic [7:0] idx_y_o;
  logic [15:0] pc_o;
  logic [7:0] cc_o;
  logic [15:0] sp_o;
  logic branch_taken_o;
  logic [15:0] stk_addr_o;
  logic [7:0] stk_wdata_o;
  logic stk_we_o;
  logic stk_re_o;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] stk_mem [0:255];
  logic [15:0] wr_addr [0:63];
  logic [7:0] wr_data [0:63];
  int wr_cnt = 0;
  int b;
  logic [7:0] irq_d [5] = '{8'hcd, 8'hab, 8'h34, 8'h12, 8'he8};
  logic [2:0] fbit [4] = '{3'd4, 3'd2, 3'd1, 3'd0};
  ccr_op_e pops [6] = '{OP_SIM, OP_RIM, OP_SIM, OP_HALT, OP_SIM, OP_WFI};
  logic [1:0] pexp [6] = '{2'b11, 2'b10, 2'b11, 2'b10, 2'b11, 2'b10};

  ccr_core_regs #(.SP_HI(SPH)) ccr_core_regs_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .reg_sel_i(reg_sel_i), .alt_index_i(alt_index_i), .operand_i(operand_i),
    .alu_result_i(alu_result_i), .alu_carry_i(alu_carry_i), .flag_sel_i(flag_sel_i),
    .branch_on_set_i(branch_on_set_i), .bit_sel_i(bit_sel_i), .pc_i(pc_i),
    .isp_i(isp_i), .stk_rdata_i(stk_rdata_i), .busy_o(busy_o), .acc_o(acc_o),
    .idx_x_o(idx_x_o), .idx_y_o(idx_y_o), .pc_o(pc_o), .cc_o(cc_o), .sp_o(sp_o),
    .branch_taken_o(branch_taken_o), .stk_addr_o(stk_addr_o),
    .stk_wdata_o(stk_wdata_o), .stk_we_o(stk_we_o), .stk_re_o(stk_re_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // stack memory; read data only valid the cycle after the strobe, garbage otherwise
  always @(posedge sys_clk_i)
  begin
    if (stk_we_o === 1'b1)
    begin
      stk_mem[stk_addr_o[7:0]] <= stk_wdata_o;
      wr_addr[wr_cnt % 64] <= stk_addr_o;
      wr_data[wr_cnt % 64] <= stk_wdata_o;
      wr_cnt <= wr_cnt + 1;
    end
    if (stk_re_o === 1'b1)
      stk_rdata_i <= stk_mem[stk_addr_o[7:0]];
    else
      stk_rdata_i <= ~stk_rdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // one op, then wait out any stack sequence it started
  task automatic do_op(input ccr_op_e o, input ccr_reg_e r = REG_A,
                       input logic [7:0] v = 8'h00, input logic [15:0] pc = 16'h0000,
                       input logic [1:0] isp = 2'b00, input logic alt = 1'b0,
                       input logic [7:0] res = 8'h00, input logic cy = 1'b0,
                       input ccr_flag_e fl = FLG_H, input logic ons = 1'b0,
                       input logic [2:0] bs = 3'd0);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    op_valid_i <= 1'b1;
    op_i <= o;
    reg_sel_i <= r;
    operand_i <= v;
    pc_i <= pc;
    isp_i <= isp;
    alt_index_i <= alt;
    alu_result_i <= res;
    alu_carry_i <= cy;
    flag_sel_i <= fl;
    branch_on_set_i <= ons;
    bit_sel_i <= bs;
    @(posedge sys_clk_i);
    op_valid_i <= 1'b0;
    #1;
    while (busy_o !== 1'b0 && n < 40)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 40)
    begin
      errors++;
      $display("[FAIL] busy_o expected 0 seen %b", busy_o);
    end
  endtask : do_op

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    close_out();
  end

  initial
  begin
    rst_i <= 1'b1;
    op_valid_i <= 1'b0;
    op_i <= OP_NOP;
    reg_sel_i <= REG_A;
    alt_index_i <= 1'b0;
    operand_i <= 8'h00;
    alu_result_i <= 8'h00;
    alu_carry_i <= 1'b0;
    flag_sel_i <= FLG_H;
    branch_on_set_i <= 1'b0;
    bit_sel_i <= 3'd0;
    pc_i <= 16'h0000;
    isp_i <= 2'b00;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    chk("sp_reset", {SPH, 8'hff}, sp_o);
    chk("cc_reset", 16'h00e8, {8'h00, cc_o});
    chk("acc_reset", 16'h0000, {8'h00, acc_o});
    chk("busy_reset", 16'h0000, {15'd0, busy_o});
    // index registers and program counter
    do_op(.o(OP_LOAD), .r(REG_X), .alt(1'b1), .v(8'h56));
    do_op(.o(OP_LOAD), .r(REG_X), .v(8'h34));
    do_op(.o(OP_LOAD), .r(REG_A), .v(8'h12));
    chk("idx_y", 16'h0056, {8'h00, idx_y_o});
    chk("idx_x", 16'h0034, {8'h00, idx_x_o});
    chk("acc", 16'h0012, {8'h00, acc_o});
    do_op(.o(OP_CCBIT), .bs(3'd4), .v(8'h00));
    do_op(.o(OP_RCF));
    do_op(.o(OP_SIM));
    do_op(.o(OP_JUMP), .pc(16'habcd));
    chk("pc_jump", 16'habcd, pc_o);
    chk("cc_known", 16'h00e8, {8'h00, cc_o});
    // interrupt entry: five bytes, low pc byte at the top
    b = wr_cnt;
    do_op(.o(OP_IRQ), .pc(16'h8000), .isp(2'b01));
    chk("irq_bytes", 16'd5, 16'(wr_cnt - b));
    for (int k = 0; k < 5; k++)
    begin
      chk("irq_addr", {SPH, 8'hff} - 16'(k), wr_addr[(b + k) % 64]);
      chk("irq_data", {8'h00, irq_d[k]}, {8'h00, wr_data[(b + k) % 64]});
    end
    chk("irq_sp", {SPH, 8'hfa}, sp_o);
    chk("irq_pc", 16'h8000, pc_o);
    chk("irq_prio", 16'h0001, {14'd0, cc_o[5], cc_o[3]});
    chk("irq_y", 16'h0056, {8'h00, idx_y_o});
    do_op(.o(OP_LOAD), .r(REG_A), .v(8'h00));
    do_op(.o(OP_INTERRUPT_RETURN_INSTR));
    chk("interrupt_return_instr_acc", 16'h0012, {8'h00, acc_o});
    chk("interrupt_return_instr_x", 16'h0034, {8'h00, idx_x_o});
    chk("interrupt_return_instr_pc", 16'habcd, pc_o);
    chk("interrupt_return_instr_cc", 16'h00e8, {8'h00, cc_o});
    chk("interrupt_return_instr_sp", {SPH, 8'hff}, sp_o);
    chk("interrupt_return_instr_y", 16'h0056, {8'h00, idx_y_o});
    // subroutine call and return
    b = wr_cnt;
    do_op(.o(OP_CALL), .pc(16'h2000));
    chk("call_bytes", 16'd2, 16'(wr_cnt - b));
    chk("call_lo", {8'h00, 8'hcd}, {8'h00, wr_data[b % 64]});
    chk("call_hi", {8'h00, 8'hab}, {8'h00, wr_data[(b + 1) % 64]});
    chk("call_sp", {SPH, 8'hfd}, sp_o);
    chk("call_pc", 16'h2000, pc_o);
    do_op(.o(OP_RET));
    chk("ret_pc", 16'habcd, pc_o);
    chk("ret_sp", {SPH, 8'hff}, sp_o);
    // whole condition-code byte through the stack
    do_op(.o(OP_PUSH), .r(REG_CC));
    do_op(.o(OP_SCF));
    do_op(.o(OP_RIM));
    chk("cc_changed", 16'h00e1, {8'h00, cc_o});
    do_op(.o(OP_POP), .r(REG_CC));
    chk("cc_popped", 16'h00e8, {8'h00, cc_o});
    // wrap at both stack limits
    do_op(.o(OP_LDSP), .v(8'h00));
    chk("sp_load", {SPH, 8'h00}, sp_o);
    do_op(.o(OP_PUSH), .r(REG_A));
    chk("sp_wrap_dn", {SPH, 8'hff}, sp_o);
    do_op(.o(OP_POP), .r(REG_X));
    chk("sp_wrap_up", {SPH, 8'h00}, sp_o);
    chk("pop_x", 16'h0012, {8'h00, idx_x_o});
    do_op(.o(OP_RSP));
    chk("sp_rsp", {SPH, 8'hff}, sp_o);
    // arithmetic flags {h,n,z,c}
    do_op(.o(OP_LOAD), .r(REG_A), .v(8'h0f));
    do_op(.o(OP_ADD), .v(8'h01));
    chk("add_flags", 16'h0008, {12'd0, cc_o[4], cc_o[2:0]});
    do_op(.o(OP_ADD), .v(8'hf0));
    chk("add_acc", 16'h0000, {8'h00, acc_o});
    chk("add_flags2", 16'h0003, {12'd0, cc_o[4], cc_o[2:0]});
    do_op(.o(OP_ADC), .v(8'h7f));
    chk("adc_acc", 16'h0080, {8'h00, acc_o});
    chk("adc_flags", 16'h000c, {12'd0, cc_o[4], cc_o[2:0]});
    do_op(.o(OP_ALU), .res(8'h00));
    chk("alu_nz", 16'h0001, {14'd0, cc_o[2:1]});
    do_op(.o(OP_ALU), .res(8'h80));
    chk("alu_nz2", 16'h0002, {14'd0, cc_o[2:1]});
    do_op(.o(OP_SHIFT), .res(8'h01), .cy(1'b1));
    chk("shift_c", 16'h0001, {15'd0, cc_o[0]});
    do_op(.o(OP_BTJ), .cy(1'b0));
    chk("btj_c", 16'h0000, {15'd0, cc_o[0]});
    do_op(.o(OP_SCF));
    chk("scf_c", 16'h0001, {15'd0, cc_o[0]});
    do_op(.o(OP_RCF));
    chk("rcf_c", 16'h0000, {15'd0, cc_o[0]});
    // branches on every flag, both senses
    for (int i = 0; i < 4; i++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        do_op(.o(OP_CCBIT), .bs(fbit[i]), .v({7'd0, s[0]}));
        do_op(.o(OP_BRANCH), .fl(ccr_flag_e'(i)), .ons(1'b1), .pc(16'h0040));
        chk("br_set", {15'd0, s[0]}, {15'd0, branch_taken_o});
        do_op(.o(OP_BRANCH), .fl(ccr_flag_e'(i)), .ons(1'b0), .pc(16'h0040));
        chk("br_clr", {15'd0, ~s[0]}, {15'd0, branch_taken_o});
      end
    end
    // priority changes by instruction
    for (int i = 0; i < 6; i++)
    begin
      do_op(.o(pops[i]));
      chk("prio", {14'd0, pexp[i]}, {14'd0, cc_o[5], cc_o[3]});
    end
    do_op(.o(OP_CCBIT), .bs(3'd7), .v(8'h00));
    do_op(.o(OP_CCBIT), .bs(3'd6), .v(8'h00));
    chk("cc_fixed", 16'h0003, {14'd0, cc_o[7:6]});
    close_out();
  end
endmodule : cpu_core_registers_bench
